/* File: vmp_params.svh */
// Offsets, field positions, reset values and timing counts of the vendor mode page
`ifndef VMP_PARAMS_SVH
`define VMP_PARAMS_SVH

// Page identity
`define VMP_PAGE_CODE 6'h00
`define VMP_PAGE_LEN 8'h0E
`define VMP_PS_BIT 7
`define VMP_NUM_BYTES 16

// Byte offsets
`define VMP_OFS_CODE 4'h0
`define VMP_OFS_LEN 4'h1
`define VMP_OFS_ERQ 4'h2
`define VMP_OFS_MLR 4'h3
`define VMP_OFS_SP4 4'h4
`define VMP_OFS_DAG 4'h5
`define VMP_OFS_RAV 4'h6
`define VMP_OFS_ACC 4'h8
`define VMP_OFS_TEMP 4'h9
`define VMP_OFS_AGE_HI 4'hA
`define VMP_OFS_AGE_LO 4'hB
`define VMP_OFS_RD_THR 4'hC
`define VMP_OFS_WR_THR 4'hD
`define VMP_OFS_RFC 4'hE
`define VMP_OFS_CIC 4'hF

// Reset values
`define VMP_RST_ERQ 8'h51
`define VMP_RST_MLR 8'h21
`define VMP_RST_DAG 8'h12
`define VMP_RST_ACC 8'h40
`define VMP_RST_AGE_LO 8'h30
`define VMP_RST_THR 8'h0A

// Bit positions
`define VMP_B_QPE 7
`define VMP_B_UQE 6
`define VMP_B_UAI 4
`define VMP_B_MRG 3
`define VMP_B_AUTO_REASSIGN_HARD_ERROR 0
`define VMP_B_ASDP 7
`define VMP_B_COMMAND_ACTIVE_LED 5
`define VMP_B_REPORT_NON_DATA_ERRORS 1
`define VMP_B_CPE 0
`define VMP_B_FDD 4
`define VMP_B_AGING_ENABLE 1
`define VMP_B_IGNORE_REASSIGNED 7
`define VMP_B_AUDIO_VISUAL_RECOVERY 6
`define VMP_B_ADC 6
`define VMP_B_DRRT 7
`define VMP_B_FFMT 5
`define VMP_B_FCERT 4
`define VMP_B_IRT 1
`define VMP_B_IVR 0
`define VMP_LED_MODE_MSB 3
`define VMP_LED_MODE_LSB 0

// Led modes
`define VMP_LED_BY_COMMAND_ACTIVE_LED 4'h0
`define VMP_LED_MOTOR 4'h1
`define VMP_LED_COMMAND 4'h2

// Thermal, retry, aging and candidate table figures
`define VMP_TEMP_DEFAULT_C 8'h55
`define VMP_RETRY_DEFAULT_MAX 8'h10
`define VMP_AGE_UNIT_MS 50
`define VMP_CLK_MHZ 250
`define VMP_AGE_UNIT_CYC (`VMP_AGE_UNIT_MS * `VMP_CLK_MHZ * 1000)
`define VMP_CAND_DEPTH 4

`endif

/* File: vmp_pkg.sv */
// Types shared by the vendor mode page block
package vmp_pkg;

	typedef enum logic [0:0] {
		VMP_SEL_IDLE = 1'b0,
		VMP_SEL_RECV = 1'b1
	} vmp_sel_state_t;

	typedef logic [7:0] vmp_byte_t;

endpackage

/* File: vmp_page_regs.sv */
// Vendor mode page image with select/sense access and control decoding
`timescale 1ns/10ps
`include "vmp_params.svh"

module vmp_page_regs #(
	parameter int unsigned AGE_UNIT_CYC = `VMP_AGE_UNIT_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sel_valid_i,
	input wire logic sel_first_i,
	input wire logic sel_last_i,
	input wire logic [7:0] sel_byte_i,
	output logic sel_done_o,
	output logic sel_check_o,
	input wire logic sense_rd_i,
	input wire logic [3:0] sense_idx_i,
	output logic [7:0] sense_data_o,
	input wire logic load_valid_i,
	input wire logic [3:0] load_idx_i,
	input wire logic [7:0] load_byte_i,
	input wire logic load_done_i,
	input wire logic rec_data_err_i,
	input wire logic rec_err_is_write_i,
	input wire logic [7:0] rec_err_count_i,
	input wire logic rec_nondata_err_i,
	input wire logic post_error_reporting_i,
	output logic report_data_err_o,
	output logic report_nondata_err_o,
	output logic untagged_queue_ok_o,
	input wire logic ua_jumper_i,
	output logic unit_attention_en_o,
	output logic defect_list_merge_o,
	input wire logic unrec_read_err_i,
	input wire logic [31:0] err_lba_i,
	input wire logic write_cmd_i,
	input wire logic [31:0] write_lba_i,
	output logic verify_write_o,
	input wire logic verify_done_i,
	input wire logic verify_fail_i,
	output logic reassign_req_o,
	output logic [31:0] reassign_lba_o,
	input wire logic disconnect_i,
	input wire logic had_data_phase_i,
	input wire logic more_data_i,
	output logic save_pointers_o,
	input wire logic cmd_pending_i,
	input wire logic motor_spinning_i,
	output logic led_o,
	output logic concurrent_processing_o,
	input wire logic degraded_i,
	output logic tur_degraded_o,
	output logic media_error_o,
	input wire logic oldest_changed_i,
	input wire logic queue_empty_i,
	output logic aging_fifo_order_o,
	input wire logic read_continuous_i,
	output logic skip_reassigned_o,
	input wire logic [7:0] read_retry_cnt_i,
	input wire logic [7:0] write_retry_cnt_i,
	output logic [7:0] read_retry_max_o,
	output logic [7:0] write_retry_max_o,
	output logic time_limit_en_o,
	output logic adaptive_cache_o,
	output logic [7:0] thermal_threshold_o,
	output logic format_ctrl_o,
	output logic fast_format_o,
	output logic format_certify_o,
	output logic integ_reassign_o,
	output logic integ_verify_o
);

	// ------------------------------------------------------------
	// Page image and select shadow
	// ------------------------------------------------------------
	logic [7:0] page_q [`VMP_NUM_BYTES];
	logic [7:0] shadow_q [`VMP_NUM_BYTES];
	logic [3:0] sel_idx_q;
	vmp_pkg::vmp_sel_state_t sel_state_q;
	logic params_loaded_q;

	// Reset image of one byte; ignored and spare bytes start at zero
	function automatic logic [7:0] rst_byte(input logic [3:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			`VMP_OFS_LEN: v = `VMP_PAGE_LEN;
			`VMP_OFS_ERQ: v = `VMP_RST_ERQ;
			`VMP_OFS_MLR: v = `VMP_RST_MLR;
			`VMP_OFS_DAG: v = `VMP_RST_DAG;
			`VMP_OFS_ACC: v = `VMP_RST_ACC;
			`VMP_OFS_AGE_LO: v = `VMP_RST_AGE_LO;
			`VMP_OFS_RD_THR: v = `VMP_RST_THR;
			`VMP_OFS_WR_THR: v = `VMP_RST_THR;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Select byte arrives; first byte always lands at offset zero
	wire sel_take = sel_valid_i && (sel_first_i || sel_state_q == vmp_pkg::VMP_SEL_RECV);
	wire [3:0] sel_wr_idx = sel_first_i ? 4'h0 : sel_idx_q;
	wire [7:0] len_seen = (sel_wr_idx == `VMP_OFS_LEN) ? sel_byte_i : shadow_q[`VMP_OFS_LEN];
	// Length must match what sense reports; a short list also fails
	wire sel_len_ok = (len_seen == `VMP_PAGE_LEN) && (sel_wr_idx == 4'hF);
	wire sel_end = sel_take && sel_last_i;
	wire sel_commit = sel_end && sel_len_ok;

	// Select receive sequencer
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_state_q <= vmp_pkg::VMP_SEL_IDLE;
			sel_idx_q <= 4'h0;
		end else if (sel_end) begin
			sel_state_q <= vmp_pkg::VMP_SEL_IDLE;
			sel_idx_q <= 4'h0;
		end else if (sel_take) begin
			case (sel_state_q)
				vmp_pkg::VMP_SEL_IDLE: sel_state_q <= vmp_pkg::VMP_SEL_RECV;
				vmp_pkg::VMP_SEL_RECV: sel_state_q <= vmp_pkg::VMP_SEL_RECV;
				default: sel_state_q <= vmp_pkg::VMP_SEL_IDLE;
			endcase
			sel_idx_q <= sel_wr_idx + 4'h1;
		end
	end

	// Shadow keeps the image untouched until the whole list checks out
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `VMP_NUM_BYTES; i++) begin
				shadow_q[i] <= 8'h00;
			end
		end else if (sel_take) begin
			shadow_q[sel_wr_idx] <= sel_byte_i;
		end
	end

	// Image update: select commit wins over saved-value loading
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `VMP_NUM_BYTES; i++) begin
				page_q[i] <= rst_byte(4'(i));
			end
		end else if (sel_commit) begin
			// Header bytes are fixed; every other byte takes any value
			for (int i = 2; i < `VMP_NUM_BYTES - 1; i++) begin
				page_q[i] <= shadow_q[i];
			end
			page_q[`VMP_NUM_BYTES - 1] <= sel_byte_i;
		end else if (load_valid_i && load_idx_i > `VMP_OFS_LEN) begin
			page_q[load_idx_i] <= load_byte_i;
		end
	end

	// Select answer and saved-values flag
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_done_o <= 1'b0;
			sel_check_o <= 1'b0;
			params_loaded_q <= 1'b0;
		end else begin
			sel_done_o <= sel_end;
			sel_check_o <= sel_end && !sel_len_ok;
			if (load_done_i) begin
				params_loaded_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Sense read
	// ------------------------------------------------------------
	// Byte zero carries the savable flag and the page code
	wire [7:0] code_byte = {1'b1, 1'b0, `VMP_PAGE_CODE};
	wire [7:0] sense_byte = (sense_idx_i == `VMP_OFS_CODE) ? code_byte : page_q[sense_idx_i];

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sense_data_o <= 8'h00;
		end else if (sense_rd_i) begin
			sense_data_o <= sense_byte;
		end
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	wire qualify_post_error = page_q[`VMP_OFS_ERQ][`VMP_B_QPE];
	wire untagged_queue_enable = page_q[`VMP_OFS_ERQ][`VMP_B_UQE];
	wire attention_inhibit = page_q[`VMP_OFS_ERQ][`VMP_B_UAI];
	wire defect_list_merge = page_q[`VMP_OFS_ERQ][`VMP_B_MRG];
	wire auto_reassign_hard_error = page_q[`VMP_OFS_ERQ][`VMP_B_AUTO_REASSIGN_HARD_ERROR];
	wire extra_save_pointer = page_q[`VMP_OFS_MLR][`VMP_B_ASDP];
	wire command_active_led = page_q[`VMP_OFS_MLR][`VMP_B_COMMAND_ACTIVE_LED];
	wire report_non_data_errors = page_q[`VMP_OFS_MLR][`VMP_B_REPORT_NON_DATA_ERRORS];
	wire [3:0] led_mode = page_q[`VMP_OFS_SP4][`VMP_LED_MODE_MSB:`VMP_LED_MODE_LSB];
	wire format_degraded_disable = page_q[`VMP_OFS_DAG][`VMP_B_FDD];
	wire aging_enable = page_q[`VMP_OFS_DAG][`VMP_B_AGING_ENABLE];
	wire ignore_reassigned = page_q[`VMP_OFS_RAV][`VMP_B_IGNORE_REASSIGNED];
	wire audio_visual_recovery = page_q[`VMP_OFS_RAV][`VMP_B_AUDIO_VISUAL_RECOVERY];
	wire [15:0] age_limit = {page_q[`VMP_OFS_AGE_HI], page_q[`VMP_OFS_AGE_LO]};
	wire [7:0] thr_sel = rec_err_is_write_i ? page_q[`VMP_OFS_WR_THR] : page_q[`VMP_OFS_RD_THR];

	// Error reporting decisions
	wire rep_data = rec_data_err_i && (!qualify_post_error || rec_err_count_i > thr_sel);
	wire rep_nondata = rec_nondata_err_i && post_error_reporting_i && report_non_data_errors;

	// Save pointers before loading, always; then by the extra bit or data need
	wire need_ptr = !params_loaded_q || extra_save_pointer
		|| (had_data_phase_i && more_data_i);

	// Led source by mode; other modes leave it dark
	wire led_cmd = command_active_led ? cmd_pending_i : motor_spinning_i;
	wire led_next = (led_mode == `VMP_LED_BY_COMMAND_ACTIVE_LED) ? led_cmd :
		(led_mode == `VMP_LED_MOTOR) ? motor_spinning_i :
		(led_mode == `VMP_LED_COMMAND) ? cmd_pending_i : 1'b0;

	// Retry caps from the error recovery page
	function automatic logic [7:0] retry_cap(input logic [7:0] cnt, input logic av);
		logic [7:0] r;
		r = 8'h00;
		if (av) begin
			r = cnt;
		end else if (cnt != 8'h00) begin
			r = `VMP_RETRY_DEFAULT_MAX;
		end
		return r;
	endfunction

	// Controls and per-event report and save-pointer decisions registered onto the outputs
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			report_data_err_o <= 1'b0;
			report_nondata_err_o <= 1'b0;
			untagged_queue_ok_o <= 1'b0;
			unit_attention_en_o <= 1'b1;
			defect_list_merge_o <= 1'b0;
			save_pointers_o <= 1'b0;
			led_o <= 1'b0;
			concurrent_processing_o <= 1'b1;
			tur_degraded_o <= 1'b0;
			media_error_o <= 1'b0;
			skip_reassigned_o <= 1'b0;
			read_retry_max_o <= 8'h00;
			write_retry_max_o <= 8'h00;
			time_limit_en_o <= 1'b0;
			adaptive_cache_o <= 1'b0;
			thermal_threshold_o <= `VMP_TEMP_DEFAULT_C;
			format_ctrl_o <= 1'b0;
			fast_format_o <= 1'b0;
			format_certify_o <= 1'b0;
			integ_reassign_o <= 1'b0;
			integ_verify_o <= 1'b0;
		end else begin
			report_data_err_o <= rep_data;
			report_nondata_err_o <= rep_nondata;
			untagged_queue_ok_o <= untagged_queue_enable;
			unit_attention_en_o <= !(ua_jumper_i && attention_inhibit);
			defect_list_merge_o <= defect_list_merge;
			save_pointers_o <= disconnect_i && need_ptr;
			led_o <= led_next;
			// The stored bit is only echoed on sense; execution is concurrent anyway
			concurrent_processing_o <= 1'b1;
			tur_degraded_o <= degraded_i && !format_degraded_disable;
			media_error_o <= degraded_i && !format_degraded_disable;
			skip_reassigned_o <= read_continuous_i && ignore_reassigned;
			read_retry_max_o <= retry_cap(read_retry_cnt_i, audio_visual_recovery);
			write_retry_max_o <= retry_cap(write_retry_cnt_i, audio_visual_recovery);
			time_limit_en_o <= audio_visual_recovery;
			adaptive_cache_o <= page_q[`VMP_OFS_ACC][`VMP_B_ADC];
			thermal_threshold_o <= (page_q[`VMP_OFS_TEMP] == 8'h00) ?
				`VMP_TEMP_DEFAULT_C : page_q[`VMP_OFS_TEMP];
			format_ctrl_o <= page_q[`VMP_OFS_RFC][`VMP_B_DRRT];
			fast_format_o <= page_q[`VMP_OFS_RFC][`VMP_B_FFMT];
			format_certify_o <= page_q[`VMP_OFS_CIC][`VMP_B_FCERT];
			integ_reassign_o <= page_q[`VMP_OFS_CIC][`VMP_B_IRT];
			integ_verify_o <= page_q[`VMP_OFS_CIC][`VMP_B_IVR];
		end
	end

	// ------------------------------------------------------------
	// Command aging
	// ------------------------------------------------------------
	logic [31:0] unit_cnt_q;
	logic [15:0] age_q;
	wire unit_tick = (unit_cnt_q == 32'(AGE_UNIT_CYC - 1));

	// Age of the oldest queued command in fifty millisecond units
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			unit_cnt_q <= 32'h0000_0000;
			age_q <= 16'h0000;
		end else if (queue_empty_i || oldest_changed_i) begin
			unit_cnt_q <= 32'h0000_0000;
			age_q <= 16'h0000;
		end else begin
			unit_cnt_q <= unit_tick ? 32'h0000_0000 : unit_cnt_q + 32'h0000_0001;
			if (unit_tick && age_q != 16'hFFFF) begin
				age_q <= age_q + 16'h0001;
			end
		end
	end

	// Oldest overdue: serve in arrival order, else normal reordering
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aging_fifo_order_o <= 1'b0;
		end else begin
			aging_fifo_order_o <= aging_enable && !queue_empty_i && (age_q > age_limit);
		end
	end

	// ------------------------------------------------------------
	// Hard error reassign candidates
	// ------------------------------------------------------------
	// Flop table; a full table drops new candidates rather than evict old ones
	logic [31:0] cand_lba_q [`VMP_CAND_DEPTH];
	logic [`VMP_CAND_DEPTH-1:0] cand_vld_q;
	logic [1:0] pend_idx_q;
	logic pend_q;

	// Index of the entry holding a block, with a hit flag on top
	function automatic logic [2:0] cand_find(input logic [31:0] lba,
		input logic [31:0] tab [`VMP_CAND_DEPTH], input logic [`VMP_CAND_DEPTH-1:0] vld);
		logic [2:0] r;
		r = 3'b000;
		for (int i = `VMP_CAND_DEPTH - 1; i >= 0; i--) begin
			if (vld[i] && tab[i] == lba) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	wire [2:0] err_hit = cand_find(err_lba_i, cand_lba_q, cand_vld_q);
	wire [2:0] wr_hit = cand_find(write_lba_i, cand_lba_q, cand_vld_q);
	wire [2:0] free_slot = cand_find(32'h0000_0000, '{default: 32'h0000_0000}, ~cand_vld_q);
	// Page one reallocation enables play no part here
	wire cand_add = auto_reassign_hard_error && unrec_read_err_i && !err_hit[2] && free_slot[2];
	wire cand_chk = auto_reassign_hard_error && write_cmd_i && wr_hit[2] && !pend_q;
	wire cand_end = pend_q && verify_done_i;

	// Candidate bookkeeping and write-verify outcome
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `VMP_CAND_DEPTH; i++) begin
				cand_lba_q[i] <= 32'h0000_0000;
			end
			cand_vld_q <= '0;
			pend_q <= 1'b0;
			pend_idx_q <= 2'b00;
			verify_write_o <= 1'b0;
			reassign_req_o <= 1'b0;
			reassign_lba_o <= 32'h0000_0000;
		end else begin
			verify_write_o <= cand_chk;
			reassign_req_o <= cand_end && verify_fail_i;
			if (cand_add) begin
				cand_lba_q[free_slot[1:0]] <= err_lba_i;
				cand_vld_q[free_slot[1:0]] <= 1'b1;
			end
			if (cand_chk) begin
				pend_q <= 1'b1;
				pend_idx_q <= wr_hit[1:0];
			end else if (cand_end) begin
				// Either way the candidate is retired: reassigned or cleared
				pend_q <= 1'b0;
				cand_vld_q[pend_idx_q] <= 1'b0;
				reassign_lba_o <= cand_lba_q[pend_idx_q];
			end
		end
	end

endmodule

/* File: vmp_page_chk.sv */
// Concurrent checks on the vendor mode page block ports
`timescale 1ns/10ps
module vmp_page_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sel_valid_i,
	input wire logic sel_first_i,
	input wire logic sel_last_i,
	input wire logic [7:0] sel_byte_i,
	input wire logic sel_done_o,
	input wire logic sel_check_o,
	input wire logic load_done_i,
	input wire logic rec_data_err_i,
	input wire logic rec_nondata_err_i,
	input wire logic post_error_reporting_i,
	input wire logic report_data_err_o,
	input wire logic report_nondata_err_o,
	input wire logic ua_jumper_i,
	input wire logic unit_attention_en_o,
	input wire logic write_cmd_i,
	input wire logic verify_write_o,
	input wire logic verify_done_i,
	input wire logic verify_fail_i,
	input wire logic reassign_req_o,
	input wire logic disconnect_i,
	input wire logic save_pointers_o,
	input wire logic concurrent_processing_o,
	input wire logic [7:0] thermal_threshold_o,
	input wire logic read_continuous_i,
	input wire logic skip_reassigned_o,
	input wire logic aging_fifo_order_o
);
	// ----------------------------------------
	// Select tracking
	// ----------------------------------------
	logic [4:0] pos_q;
	logic len_bad_q;
	logic loaded_q;
	wire logic [4:0] cur_pos = sel_first_i ? 5'h00 : pos_q;
	wire logic full_last = sel_valid_i && sel_last_i && cur_pos == 5'h0f;

	// Byte index and length verdict of the select in flight
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_q <= 5'h00;
			len_bad_q <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			if (sel_valid_i) pos_q <= cur_pos + 5'h01;
			if (sel_valid_i && cur_pos == 5'h01) len_bad_q <= sel_byte_i != 8'h0e;
			if (load_done_i) loaded_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_len_refused: assert property (full_last && len_bad_q |=> sel_done_o && sel_check_o)
		else $error("bad page length accepted");
	a_len_taken: assert property (full_last && !len_bad_q |=> sel_done_o && !sel_check_o)
		else $error("good select refused");
	a_done_cause: assert property (sel_done_o |-> $past(sel_valid_i && sel_last_i))
		else $error("select ended without last byte");
	a_save_early: assert property (disconnect_i && !loaded_q && !load_done_i |=> save_pointers_o)
		else $error("no save pointers before load");
	a_save_cause: assert property (save_pointers_o |-> $past(disconnect_i))
		else $error("save pointers without disconnect");
	a_data_rpt: assert property (report_data_err_o |-> $past(rec_data_err_i))
		else $error("data error report without cause");
	a_nondata_gate: assert property (report_nondata_err_o |-> $past(rec_nondata_err_i && post_error_reporting_i))
		else $error("non-data report not gated");
	a_ua_no_jumper: assert property (!ua_jumper_i |=> unit_attention_en_o)
		else $error("attention inhibited without jumper");
	a_conc_fixed: assert property (concurrent_processing_o)
		else $error("concurrent processing dropped");
	a_thermal_set: assert property (thermal_threshold_o != 8'h00)
		else $error("thermal threshold zero");
	a_reassign_cause: assert property (reassign_req_o |-> $past(verify_done_i && verify_fail_i))
		else $error("reassign without failed verify");
	a_verify_cause: assert property (verify_write_o |-> $past(write_cmd_i))
		else $error("verify without write");
	a_skip_rc: assert property (skip_reassigned_o |-> $past(read_continuous_i))
		else $error("skip without read continuous");

	c_bad_len: cover property (full_last && len_bad_q);
	c_reassign: cover property (reassign_req_o);
	c_aging: cover property (aging_fifo_order_o);
endmodule

bind vmp_page_regs vmp_page_chk u_chk (.ref_clk_i, .rst_i, .sel_valid_i, .sel_first_i, .sel_last_i, .sel_byte_i,
	.sel_done_o, .sel_check_o, .load_done_i, .rec_data_err_i, .rec_nondata_err_i, .post_error_reporting_i,
	.report_data_err_o, .report_nondata_err_o, .ua_jumper_i, .unit_attention_en_o, .write_cmd_i, .verify_write_o,
	.verify_done_i, .verify_fail_i, .reassign_req_o, .disconnect_i, .save_pointers_o, .concurrent_processing_o,
	.thermal_threshold_o, .read_continuous_i, .skip_reassigned_o, .aging_fifo_order_o);

/* File: vmp_host_model.sv */
// Initiator model that sends the vendor page by mode select
`timescale 1ns/10ps
module vmp_host_model (
	input wire logic ref_clk_i,
	input wire logic go_i,
	input wire logic gap_i,
	input wire logic [3:0] last_i,
	input wire logic [7:0] img_i [16],
	output logic sel_valid_o,
	output logic sel_first_o,
	output logic sel_last_o,
	output logic [7:0] sel_byte_o
);
	// Bytes go out in order; an idle slot shows inverted data, except the idle after a gapped page, which shows the last byte uninverted
	initial begin
		sel_valid_o = 1'b0;
		sel_first_o = 1'b0;
		sel_last_o = 1'b0;
		sel_byte_o = 8'h00;
		forever begin
			@(posedge ref_clk_i);
			if (go_i) begin
				for (int i = 0; i <= last_i; i++) begin
					sel_valid_o <= 1'b1;
					sel_first_o <= i == 0;
					sel_last_o <= i == last_i;
					sel_byte_o <= img_i[i];
					@(posedge ref_clk_i);
					if (gap_i) begin
						sel_valid_o <= 1'b0;
						sel_first_o <= 1'b0;
						sel_last_o <= 1'b0;
						sel_byte_o <= ~img_i[i];
						@(posedge ref_clk_i);
					end
				end
				sel_valid_o <= 1'b0;
				sel_last_o <= 1'b0;
				sel_byte_o <= ~sel_byte_o;
			end
		end
	end
endmodule

/* File: vendor_mode_page_params_tb.sv */
// Self-checking bench for the vendor mode page block
`timescale 1ns/10ps
`define CMP(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module vendor_mode_page_params_tb;
	// ----------------------------------------
	// Signals and reference image
	// ----------------------------------------
	logic ref_clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, gap = 1'b0, got_chk, loaded = 1'b0;
	logic sense_rd_i = 0, load_valid_i = 0, load_done_i = 0, rec_data_err_i = 0, rec_err_is_write_i = 0;
	logic rec_nondata_err_i = 0, post_error_reporting_i = 0, ua_jumper_i = 0, unrec_read_err_i = 0;
	logic write_cmd_i = 0, verify_done_i = 0, verify_fail_i = 0, disconnect_i = 0, had_data_phase_i = 0;
	logic more_data_i = 0, cmd_pending_i = 0, motor_spinning_i = 0, degraded_i = 0, oldest_changed_i = 0;
	logic queue_empty_i = 1, read_continuous_i = 0;
	logic [3:0] sense_idx_i = 0, load_idx_i = 0, last = 0;
	logic [7:0] load_byte_i = 0, rec_err_count_i = 0, read_retry_cnt_i = 1, write_retry_cnt_i = 1, d;
	logic [31:0] err_lba_i = 0, write_lba_i = 0, reassign_lba_o;
	logic sel_valid_i, sel_first_i, sel_last_i, sel_done_o, sel_check_o, report_data_err_o, report_nondata_err_o;
	logic untagged_queue_ok_o, unit_attention_en_o, defect_list_merge_o, verify_write_o, reassign_req_o;
	logic save_pointers_o, led_o, concurrent_processing_o, tur_degraded_o, media_error_o, aging_fifo_order_o;
	logic skip_reassigned_o, time_limit_en_o, adaptive_cache_o, format_ctrl_o, fast_format_o, format_certify_o;
	logic integ_reassign_o, integ_verify_o;
	logic [7:0] sel_byte_i, sense_data_o, read_retry_max_o, write_retry_max_o, thermal_threshold_o;
	logic [7:0] tx [16];
	logic [7:0] mdl [16] = '{8'h80, 8'h0e, 8'h51, 8'h21, 0, 8'h12, 0, 0, 8'h40, 0, 0, 8'h30, 8'h0a, 8'h0a, 0, 0};
	int seed = 32'hc9a9, bad_count = 0, num_checks = 0, n_done = 0;

	// Short aging unit keeps the aging scenario to a few dozen cycles
	vmp_page_regs #(.AGE_UNIT_CYC(4)) DUT (.*);
	vmp_host_model host (.ref_clk_i, .go_i(go), .gap_i(gap), .last_i(last), .img_i(tx),
		.sel_valid_o(sel_valid_i), .sel_first_o(sel_first_i), .sel_last_o(sel_last_i), .sel_byte_o(sel_byte_i));

	// Clock, select-end monitor and watchdog
	initial forever #2 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (sel_done_o) begin
		n_done <= n_done + 1;
		got_chk <= sel_check_o;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		wrap_up;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [7:0] rb();
		return 8'($random(seed));
	endfunction

	task automatic sense(input logic [3:0] i);
		sense_rd_i <= 1'b1;
		sense_idx_i <= i;
		@(posedge ref_clk_i);
		sense_rd_i <= 1'b0;
		@(posedge ref_clk_i);
		d = sense_data_o;
	endtask

	task automatic chk_img;
		for (int i = 0; i < 16; i++) begin
			sense(4'(i));
			`CMP(d, mdl[i])
		end
	endtask

	task automatic rnd_tx;
		for (int i = 0; i < 16; i++) tx[i] = rb();
		tx[0] = 8'h00;
		tx[1] = 8'h0e;
	endtask

	// Sends tx through the initiator model; only a full, well-sized page may land in the image
	task automatic send(input logic [3:0] n);
		int d0;
		logic ok;
		d0 = n_done;
		ok = tx[1] == 8'h0e && n == 4'hf;
		last <= n;
		gap <= rb() > 8'h7f;
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		for (int k = 0; k < 60 && n_done == d0; k++) @(posedge ref_clk_i);
		`CMP(n_done, d0 + 1)
		`CMP(got_chk, !ok)
		if (ok) for (int i = 2; i < 16; i++) mdl[i] = tx[i];
	endtask

	task automatic rnd_in;
		{degraded_i, ua_jumper_i, read_continuous_i, cmd_pending_i, motor_spinning_i, post_error_reporting_i,
			had_data_phase_i, more_data_i} <= rb();
		read_retry_cnt_i <= rb() | 8'h01;
		write_retry_cnt_i <= rb() | 8'h01;
	endtask

	task automatic chk_lvl;
		logic [3:0] m;
		logic lx;
		repeat (2) @(posedge ref_clk_i);
		m = mdl[4][3:0];
		lx = m == 4'h0 ? (mdl[3][5] ? cmd_pending_i : motor_spinning_i) : m == 4'h1 ? motor_spinning_i :
			(m == 4'h2) & cmd_pending_i;
		`CMP(led_o, lx)
		`CMP(untagged_queue_ok_o, mdl[2][6])
		`CMP(unit_attention_en_o, ua_jumper_i ? !mdl[2][4] : 1'b1)
		`CMP(defect_list_merge_o, mdl[2][3])
		`CMP(concurrent_processing_o, 1'b1)
		`CMP({tur_degraded_o, media_error_o}, {2{degraded_i & !mdl[5][4]}})
		`CMP(skip_reassigned_o, read_continuous_i & mdl[6][7])
		`CMP(time_limit_en_o, mdl[6][6])
		`CMP(read_retry_max_o, mdl[6][6] ? read_retry_cnt_i : 8'h10)
		`CMP(write_retry_max_o, mdl[6][6] ? write_retry_cnt_i : 8'h10)
		`CMP(adaptive_cache_o, mdl[8][6])
		`CMP(thermal_threshold_o, mdl[9] == 8'h00 ? 8'h55 : mdl[9])
		`CMP({format_ctrl_o, fast_format_o}, {mdl[14][7], mdl[14][5]})
		`CMP({format_certify_o, integ_reassign_o, integ_verify_o}, {mdl[15][4], mdl[15][1:0]})
	endtask

	// Error reports, disconnect messaging and the hard-error candidate path
	task automatic evt;
		logic [7:0] r;
		logic [7:0] c;
		logic a;
		r = rb();
		c = {3'b000, r[7:3]};
		a = mdl[2][0];
		rec_err_is_write_i <= r[0];
		rec_err_count_i <= c;
		rec_data_err_i <= 1'b1;
		rec_nondata_err_i <= 1'b1;
		disconnect_i <= 1'b1;
		unrec_read_err_i <= 1'b1;
		err_lba_i <= {24'h00_0000, r};
		@(posedge ref_clk_i);
		{rec_data_err_i, rec_nondata_err_i, disconnect_i, unrec_read_err_i} <= 4'h0;
		@(posedge ref_clk_i);
		`CMP(report_data_err_o, !mdl[2][7] || c > (r[0] ? mdl[13] : mdl[12]))
		`CMP(report_nondata_err_o, post_error_reporting_i & mdl[3][1])
		`CMP(save_pointers_o, !loaded | mdl[3][7] | (had_data_phase_i & more_data_i))
		for (int k = 0; k < 2; k++) begin
			write_cmd_i <= 1'b1;
			write_lba_i <= {24'h00_0000, r};
			@(posedge ref_clk_i);
			write_cmd_i <= 1'b0;
			@(posedge ref_clk_i);
			`CMP(verify_write_o, a && k == 0)
			verify_done_i <= a && k == 0;
			verify_fail_i <= r[1];
			@(posedge ref_clk_i);
			verify_done_i <= 1'b0;
			@(posedge ref_clk_i);
			`CMP(reassign_req_o, a && k == 0 && r[1])
			if (a && k == 0 && r[1]) `CMP(reassign_lba_o, {24'h00_0000, r})
		end
	endtask

	task automatic age;
		queue_empty_i <= 1'b0;
		oldest_changed_i <= 1'b1;
		@(posedge ref_clk_i);
		oldest_changed_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		`CMP(aging_fifo_order_o, 1'b0)
		repeat (30) @(posedge ref_clk_i);
		`CMP(aging_fifo_order_o, mdl[5][1])
		queue_empty_i <= 1'b1;
	endtask

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] r;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk_img;
		rnd_in;
		chk_lvl;
		evt;
		// Saved values arrive before any select; bytes 0 and 1 are never written
		r = rb();
		load_idx_i <= r[3:0];
		load_byte_i <= r;
		load_valid_i <= 1'b1;
		if (r[3:1] != 3'h0) mdl[r[3:0]] = r;
		@(posedge ref_clk_i);
		load_valid_i <= 1'b0;
		load_done_i <= 1'b1;
		@(posedge ref_clk_i);
		load_done_i <= 1'b0;
		loaded = 1'b1;
		chk_img;
		rnd_tx;
		tx[1] = 8'h0d;
		send(4'hf);
		rnd_tx;
		send(4'h9);
		chk_img;
		for (int it = 0; it < 8; it++) begin
			rnd_tx;
			if (it < 4) tx[4][3:0] = 4'(it);
			tx[10] = 8'h00;
			tx[11] = 8'h02;
			send(4'hf);
			chk_img;
			rnd_in;
			chk_lvl;
			evt;
			evt;
			age;
		end
		wrap_up;
	end
endmodule
